/* File: rtl/conv_sequencer.sv */
// Multichannel shunt/bus conversion sequencer with Wishbone register access
//
// Operation
// - Mode 111 converts continuously, shunt then bus
// - After a channel, go to next enabled one
// - Disabled channels are skipped in every mode
// - Continuous mode cycles until configuration rewritten
// - Shunt-only and bus-only codes, both operations
// - Codes 001, 010, 011 start one pass
// - Single pass done: enter power-down
// - Results readable always, hold latest averaged value
// - Ready flag set when pass completes
// - Flag clears on active config write, status read
// - Allow 40 us recovery leaving power-down
// - Registers usable in power-down until active code
// - Output += (sample - output) / averaging setting
// - Pass starts channel 1 shunt, update before next
// - Enables and mode jointly select measured signals
// - Full set: five between repeats; shunt-only two
// - Separate shunt and bus conversion time fields
// - Conversion length fixed; single signal, no gap
// - Bus results carry 8 mV per count
`timescale 1ns/10ps
module conv_sequencer
   import seq_pkg::*;
#(
   parameter int CYC_PER_US   = seq_pkg::CLK_MHZ,  // Cycles per microsecond
   parameter int RECOVERY_CYC = seq_pkg::WAKE_CYC  // Power-down recovery cycles
) (
   input  wire logic              MCLK,     // System clock, 125 MHz
   input  wire logic              RST_N,    // Asynchronous reset, active low
   input  wire logic              CE,       // Clock enable, freezes all state
   input  wire logic [7:0]        ADR_I,    // Wishbone byte address
   input  wire logic [31:0]       DAT_I,    // Wishbone write data
   output logic      [31:0]       DAT_O,    // Wishbone read data
   input  wire logic [3:0]        SEL_I,    // Wishbone byte selects
   input  wire logic              WE_I,     // Wishbone write enable
   input  wire logic              STB_I,    // Wishbone strobe
   input  wire logic              CYC_I,    // Wishbone cycle
   output logic                   ACK_O,    // Wishbone acknowledge
   input  wire logic [15:0]       ADC_DATA, // Front end result at conversion end
   output seq_pkg::adc_cmd_s      ADC_CMD   // Front end command
);
   import seq_pkg::*;

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (CYC_PER_US < 1 || CYC_PER_US > 250) begin : g_chk_rate
      $error("conv_sequencer: CYC_PER_US out of range 1..250");
   end
   if (RECOVERY_CYC < 1 || RECOVERY_CYC >= (1 << CNT_W)) begin : g_chk_wake
      $error("conv_sequencer: RECOVERY_CYC does not fit the counter");
   end

   localparam logic [CNT_W-1:0] WAKE_LOAD = CNT_W'(RECOVERY_CYC);
   localparam logic [2:0]       NO_SLOT   = 3'h7;

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------
   function automatic reg_sel_e reg_decode(input logic [7:0] adr);
      reg_sel_e s;
      s = RS_NONE;
      if (adr == OFS_CONFIG) begin
         s = RS_CFG;
      end else if (adr == OFS_MASK_EN) begin
         s = RS_MSK;
      end else if (adr >= OFS_RESULT0 && adr < OFS_MASK_EN && adr[1:0] == 2'b00) begin
         s = RS_RES;
      end
      return s;
   endfunction

   // Slot 2k is channel k+1 shunt, slot 2k+1 its bus signal
   function automatic logic slot_ok(input logic [2:0] slot, input cfg_s c);
      logic sig_on;
      sig_on = slot[0] ? c.mode[MODE_BUS] : c.mode[MODE_SHUNT];
      return (slot < 3'(N_SLOTS)) && c.ch_en[slot[2:1]] && sig_on;
   endfunction

   function automatic logic [2:0] next_slot(input logic [2:0] from, input cfg_s c);
      logic [2:0] r;
      r = NO_SLOT;
      for (int i = N_SLOTS - 1; i >= 0; i--) begin
         if (3'(i) >= from && slot_ok(3'(i), c)) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [CNT_W-1:0] conv_cycles(input logic [2:0] slot,
                                                    input cfg_s c);
      logic [2:0] code;
      code = slot[0] ? c.bus_ct : c.shunt_ct;
      return CNT_W'(CT_US[code] * CYC_PER_US);
   endfunction

   function automatic logic mode_active(input logic [2:0] m);
      return m[MODE_SHUNT] | m[MODE_BUS];
   endfunction

   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   cfg_s             cfg_r;
   cfg_s             cfg_nxt;
   st_e              st_r;
   logic [2:0]       slot_r;
   logic [CNT_W-1:0] cnt_r;
   logic             flag_r;
   logic             pend_r;
   logic             avg_go_r;
   logic             avg_last_r;
   logic [2:0]       avg_slot_r;
   logic [15:0]      sample_r;
   logic             pass_empty_set;
   reg_sel_e         sel;
   logic             commit;
   logic             cfg_wr;
   logic             msk_rd;
   logic [2:0]       res_idx;
   logic [15:0]      ra_data;
   logic [15:0]      old_val;
   logic [2:0]       nxt_in;
   logic [2:0]       nxt_wrap;
   logic [2:0]       first_slot;
   logic signed [17:0] diff;
   logic signed [17:0] avg_sum;
   logic [15:0]      avg_val;

   // ------------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------------
   assign sel     = reg_decode(ADR_I);
   assign res_idx = 3'((ADR_I - OFS_RESULT0) >> 2);
   assign commit  = pend_r;
   assign cfg_wr  = commit && WE_I && (sel == RS_CFG);
   assign msk_rd  = commit && !WE_I && (sel == RS_MSK);

   always_comb begin
      cfg_nxt = cfg_r;
      if (SEL_I[0]) begin
         cfg_nxt[7:0] = DAT_I[7:0];
      end
      if (SEL_I[1]) begin
         cfg_nxt[15:8] = DAT_I[15:8];
      end
      cfg_nxt = cfg_s'(16'(cfg_nxt) & CONFIG_WMASK);
   end

   // Request seen, answer one cycle later; ack never held two cycles
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         pend_r <= 1'b0;
         ACK_O  <= 1'b0;
      end else if (CE) begin
         pend_r <= CYC_I && STB_I && !pend_r && !ACK_O;
         ACK_O  <= pend_r;
      end
   end

   // Read data for every register, any state
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         DAT_O <= 32'h0000_0000;
      end else if (CE && commit) begin
         case (sel)
            RS_CFG:  DAT_O <= {16'h0000, cfg_r};
            RS_RES:  DAT_O <= {16'h0000, ra_data};
            RS_MSK:  DAT_O <= {29'h0, (st_r == ST_OFF), (st_r == ST_CONV), flag_r};
            default: DAT_O <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_r <= cfg_s'(CONFIG_RST);
      end else if (CE && cfg_wr) begin
         cfg_r <= cfg_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Conversion-ready flag
   // ------------------------------------------------------------------
   // A completing pass wins over a clear in the same cycle
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         flag_r <= 1'b0;
      end else if (CE) begin
         if ((avg_go_r && avg_last_r) || pass_empty_set) begin
            flag_r <= 1'b1;
         // Clear on active config write or status read
         end else if ((cfg_wr && mode_active(cfg_nxt.mode)) || msk_rd) begin
            flag_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   // Next enabled signal after the current one
   assign nxt_in     = next_slot(3'(slot_r + 3'h1), cfg_r);
   // Every pass starts from slot 0
   assign nxt_wrap   = next_slot(3'h0, cfg_r);
   assign first_slot = nxt_wrap;
   assign pass_empty_set = (st_r == ST_PICK) && (first_slot == NO_SLOT) && !cfg_wr;

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         st_r       <= ST_PICK;
         slot_r     <= 3'h0;
         cnt_r      <= '0;
         avg_go_r   <= 1'b0;
         avg_last_r <= 1'b0;
         avg_slot_r <= 3'h0;
         sample_r   <= 16'h0000;
      end else if (CE) begin
         avg_go_r <= 1'b0;
         if (cfg_wr) begin
            // Any active write starts a fresh pass
            // Rewriting the same code restarts too
            if (!mode_active(cfg_nxt.mode)) begin
               st_r <= ST_OFF;
            end else if (st_r == ST_OFF || st_r == ST_WAKE) begin
               st_r  <= ST_WAKE;
               cnt_r <= WAKE_LOAD;
            end else begin
               st_r <= ST_PICK;
            end
         end else begin
            case (st_r)
               ST_OFF: begin
                  // Stays down until an active code
                  st_r <= ST_OFF;
               end
               ST_WAKE: begin
                  if (cnt_r <= 1) begin
                     st_r <= ST_PICK;
                  end else begin
                     cnt_r <= cnt_r - 1'b1;
                  end
               end
               ST_PICK: begin
                  if (first_slot != NO_SLOT) begin
                     slot_r <= first_slot;
                     cnt_r  <= conv_cycles(first_slot, cfg_r);
                     st_r   <= ST_CONV;
                  end else if (!cfg_r.mode[MODE_CONT]) begin
                     st_r <= ST_OFF;
                  end
               end
               ST_CONV: begin
                  if (cnt_r > 1) begin
                     cnt_r <= cnt_r - 1'b1;
                  end else begin
                     // Bus code placed at 8 mV weight
                     sample_r   <= slot_r[0] ? {ADC_DATA[15-BUS_POS:0], 3'b000} : ADC_DATA;
                     avg_slot_r <= slot_r;
                     avg_go_r   <= 1'b1;
                     avg_last_r <= (nxt_in == NO_SLOT);
                     // Next conversion begins without a gap
                     // Order gives fixed spacing between repeats
                     if (nxt_in != NO_SLOT) begin
                        slot_r <= nxt_in;
                        cnt_r  <= conv_cycles(nxt_in, cfg_r);
                     // Continuous modes wrap to a new pass
                     end else if (cfg_r.mode[MODE_CONT]) begin
                        slot_r <= nxt_wrap;
                        cnt_r  <= conv_cycles(nxt_wrap, cfg_r);
                     end else begin
                        st_r <= ST_OFF;
                     end
                  end
               end
               default: st_r <= ST_OFF;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Front end command
   // ------------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         ADC_CMD <= '0;
      end else if (CE) begin
         ADC_CMD.pwr_dn  <= (st_r == ST_OFF);
         ADC_CMD.convert <= (st_r == ST_CONV) && !cfg_wr;
         ADC_CMD.chan    <= slot_r[2:1];
         ADC_CMD.bus_sel <= slot_r[0];
         // Each conversion length from its own field
         ADC_CMD.start   <= (st_r == ST_CONV) && !cfg_wr &&
                            (!ADC_CMD.convert || ADC_CMD.chan != slot_r[2:1] ||
                             ADC_CMD.bus_sel != slot_r[0] || avg_go_r);
      end
   end

   // ------------------------------------------------------------------
   // Running average and result store
   // ------------------------------------------------------------------
   // Old value plus scaled difference
   always_comb begin
      if (avg_slot_r[0]) begin
         diff = 18'(signed'({2'b00, sample_r})) - 18'(signed'({2'b00, old_val}));
      end else begin
         diff = 18'(signed'({{2{sample_r[15]}}, sample_r})) -
                18'(signed'({{2{old_val[15]}}, old_val}));
      end
      avg_sum = 18'(signed'({2'b00, old_val})) + (diff >>> AVG_SHIFT[cfg_r.avg]);
      avg_val = avg_sum[15:0];
      if (avg_slot_r[0]) begin
         avg_val[BUS_POS-1:0] = '0;
      end
   end

   // Written the cycle after its conversion ends
   result_store #(
      .W     (16),
      .DEPTH (N_SLOTS),
      .AW    (3)
   ) u_store (
      .clk     (MCLK),
      .rst_n   (RST_N),
      .ce      (CE),
      .we      (avg_go_r),
      .waddr   (avg_slot_r),
      .wdata   (avg_val),
      .ra_addr (res_idx),
      .ra_data (ra_data),
      .rb_addr (slot_r),
      .rb_data (old_val)
   );

endmodule

/* File: common/seq_pkg.sv */
// Constants, field layouts and carrier types of the conversion sequencer
package seq_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ  = 125;              // MCLK rate, 8 ns period
   localparam int WAKE_US  = 40;               // Recovery from power-down
   localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
   localparam int CNT_W    = 21;               // Conversion / wake counter width

   // Conversion time per select code, microseconds
   localparam int CT_US [8] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};

   // Averaging divisor per code, as a right shift (1,4,16,64,128,256,512,1024)
   localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
                                            4'h7, 4'h8, 4'h9, 4'hA};

   // Bus results carry an 8 mV LSB at bit 3 of the result word
   localparam int BUS_LSB_MV = 8;
   localparam int BUS_POS    = 3;

   // ------------------------------------------------------------------
   // Register map (byte offsets)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CONFIG  = 8'h00;
   localparam logic [7:0] OFS_RESULT0 = 8'h04;  // Six words, slot order
   localparam logic [7:0] OFS_MASK_EN = 8'h1C;
   localparam int         N_SLOTS     = 6;

   localparam logic [15:0] CONFIG_RST = 16'h7007;
   localparam logic [15:0] CONFIG_WMASK = 16'h7FFF;

   // Mask/enable register bits
   localparam int FLAG_BIT = 0;
   localparam int BUSY_BIT = 1;
   localparam int PD_BIT   = 2;

   // Mode field bits
   localparam int MODE_SHUNT = 0;
   localparam int MODE_BUS   = 1;
   localparam int MODE_CONT  = 2;

   typedef enum logic [1:0] {
      RS_CFG  = 2'b00,
      RS_RES  = 2'b01,
      RS_MSK  = 2'b10,
      RS_NONE = 2'b11
   } reg_sel_e;

   typedef enum logic [2:0] {
      ST_OFF  = 3'b000,
      ST_WAKE = 3'b001,
      ST_PICK = 3'b010,
      ST_CONV = 3'b011
   } st_e;

   // Configuration register layout
   typedef struct packed {
      logic       rsv;       // Bit 15, reads zero
      logic [2:0] ch_en;     // Bits 14:12, bit 12 is channel 1
      logic [2:0] avg;       // Bits 11:9
      logic [2:0] bus_ct;    // Bits 8:6
      logic [2:0] shunt_ct;  // Bits 5:3
      logic [2:0] mode;      // Bits 2:0
   } cfg_s;

   // Command to the analog front end
   typedef struct packed {
      logic       start;     // One-cycle pulse at each conversion start
      logic       convert;   // High while a conversion runs
      logic [1:0] chan;      // 0..2 for channels 1..3
      logic       bus_sel;   // 1 bus signal, 0 shunt signal
      logic       pwr_dn;    // Front end powered down
   } adc_cmd_s;

endpackage

/* File: rtl/result_store.sv */
// Result word store with one write port and two registered read ports
`timescale 1ns/10ps
module result_store #(
   parameter int W     = 16,
   parameter int DEPTH = 6,
   parameter int AW    = 3
) (
   input  wire logic          clk,      // Clock
   input  wire logic          rst_n,    // Asynchronous reset, active low
   input  wire logic          ce,       // Clock enable
   input  wire logic          we,       // Write strobe
   input  wire logic [AW-1:0] waddr,    // Write address
   input  wire logic [W-1:0]  wdata,    // Write data
   input  wire logic [AW-1:0] ra_addr,  // Read port A address
   output logic      [W-1:0]  ra_data,  // Read port A data
   input  wire logic [AW-1:0] rb_addr,  // Read port B address
   output logic      [W-1:0]  rb_data   // Read port B data
);

   if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
      $error("result_store: DEPTH does not fit AW");
   end

   logic [W-1:0] mem_r [DEPTH];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else if (ce && we && (int'(waddr) < DEPTH)) begin
         mem_r[waddr] <= wdata;
      end
   end

   // Out of range addresses read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ra_data <= '0;
         rb_data <= '0;
      end else if (ce) begin
         ra_data <= (int'(ra_addr) < DEPTH) ? mem_r[ra_addr] : '0;
         rb_data <= (int'(rb_addr) < DEPTH) ? mem_r[rb_addr] : '0;
      end
   end

endmodule

/* File: testbench/conv_seq_sva.sv */
// Port-level assertions for the conversion sequencer
`timescale 1ns/10ps
module conv_seq_sva
   import seq_pkg::*;
#(
   parameter int CYC_PER_US   = 1,  // Cycles per microsecond
   parameter int RECOVERY_CYC = 4   // Recovery cycles after power-down
) (
   input wire logic         MCLK,      // Clock
   input wire logic         RST_N,     // Reset, active low
   input wire logic         CE,        // Clock enable
   input wire logic [7:0]   ADR_I,     // Byte address
   input wire logic [31:0]  DAT_I,     // Write data
   input wire logic [31:0]  DAT_O,     // Read data
   input wire logic [3:0]   SEL_I,     // Byte selects
   input wire logic         WE_I,      // Write enable
   input wire logic         STB_I,     // Strobe
   input wire logic         CYC_I,     // Cycle
   input wire logic         ACK_O,     // Acknowledge
   input wire logic [15:0]  ADC_DATA,  // Front end result
   input seq_pkg::adc_cmd_s ADC_CMD    // Front end command
);
   // Valid only while both conversion-time codes stay at zero
   localparam int CONV = CT_US[0] * CYC_PER_US;
   logic [15:0] cnt_r;
   logic        run_r;
   logic [CNT_W-1:0] off_r;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   // ------------------------------------------------------------------
   // Helper counters
   // ------------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) cnt_r <= 16'h0000;
      else if (ADC_CMD.start) cnt_r <= 16'h0000;
      else cnt_r <= cnt_r + 16'h0001;
   end
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) run_r <= 1'b0;
      else if (ADC_CMD.start) run_r <= 1'b1;
      else if (!ADC_CMD.convert) run_r <= 1'b0;
   end
   // Saturates so that a long power-up never wraps back into range
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) off_r <= '1;
      else if (ADC_CMD.pwr_dn) off_r <= '0;
      else if (off_r != '1) off_r <= off_r + 1'b1;
   end

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   ack_pulse_a: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
   ack_delay_a: assert property ($rose(STB_I) && CYC_I |-> ##1 !ACK_O ##1 ACK_O)
      else $error("ack not on second edge");
   conv_length_a: assert property (ADC_CMD.start && run_r |-> cnt_r == 16'(CONV - 1))
      else $error("conversion length or gap wrong");
   start_inside_a: assert property (ADC_CMD.start |-> ADC_CMD.convert)
      else $error("start without convert");
   down_idle_a: assert property (ADC_CMD.pwr_dn |-> !ADC_CMD.convert)
      else $error("converting while powered down");
   wake_wait_a: assert property ($rose(ADC_CMD.convert) |-> int'(off_r) >= RECOVERY_CYC)
      else $error("conversion before recovery");
   chan_range_a: assert property (ADC_CMD.convert |-> ADC_CMD.chan != 2'b11)
      else $error("channel code out of range");
   bus_lsb_a: assert property (ACK_O && !WE_I && ADR_I[2] == 1'b0
      && ADR_I >= 8'h08 && ADR_I <= 8'h18 |-> DAT_O[2:0] == 3'b000)
      else $error("bus result low bits set");
endmodule

bind conv_sequencer conv_seq_sva #(
   .CYC_PER_US   (CYC_PER_US),
   .RECOVERY_CYC (RECOVERY_CYC)
) conv_seq_sva_i (
   .MCLK(MCLK), .RST_N(RST_N), .CE(CE), .ADR_I(ADR_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
   .SEL_I(SEL_I), .WE_I(WE_I), .STB_I(STB_I), .CYC_I(CYC_I), .ACK_O(ACK_O),
   .ADC_DATA(ADC_DATA), .ADC_CMD(ADC_CMD)
);

/* File: testbench/fe_model.sv */
// Analog front end stand-in: per-slot samples and a log of conversion starts
`timescale 1ns/10ps
module fe_model
   import seq_pkg::*;
(
   input wire logic         MCLK,      // Clock
   input wire logic         RST_N,     // Reset, active low
   input seq_pkg::adc_cmd_s ADC_CMD,   // Command from sequencer
   output logic [15:0]      ADC_DATA   // Sample to sequencer
);
   logic [2:0]  log_q [$];         // Slot of each start, oldest first
   logic [15:0] bias = 16'h0000;   // Offset set by the bench
   logic [15:0] idle_r;
   logic [15:0] base;
   // Outside conversions the data flips every cycle, so a stale sample never passes
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) idle_r <= 16'hA5A5;
      else idle_r <= ~idle_r;
   end
   always @(posedge MCLK) begin
      if (ADC_CMD.start) log_q.push_back({ADC_CMD.chan, ADC_CMD.bus_sel});
   end
   always_comb begin
      base = ADC_CMD.bus_sel ? 16'h0020 : 16'h0100;
      base = base * (16'(ADC_CMD.chan) + 16'h0001);
   end
   assign ADC_DATA = ADC_CMD.convert ? base + bias : idle_r;
endmodule

/* File: testbench/conv_sequencer_tb_top.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module conv_sequencer_tb_top;
   import seq_pkg::*;
   logic        MCLK = 1'b0;
   logic        RST_N = 1'b0;
   logic        CE = 1'b1;
   logic        WE_I = 1'b0;
   logic        STB_I = 1'b0;
   logic        CYC_I = 1'b0;
   logic [7:0]  ADR_I = 8'h00;
   logic [31:0] DAT_I = 32'h0;
   logic [3:0]  SEL_I = 4'h0;
   logic [31:0] DAT_O;
   logic        ACK_O;
   logic [15:0] ADC_DATA;
   adc_cmd_s    ADC_CMD;
   logic [31:0] rd;
   logic [2:0]  exq [$];
   logic [2:0]  modes [4] = '{3'h1, 3'h2, 3'h3, 3'h3};
   int          err_total = 0;
   int          num_checks = 0;
   int          cyc = 0;

   conv_sequencer #(.CYC_PER_US(1), .RECOVERY_CYC(4)) conv_sequencer_i (
      .MCLK(MCLK), .RST_N(RST_N), .CE(CE), .ADR_I(ADR_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
      .SEL_I(SEL_I), .WE_I(WE_I), .STB_I(STB_I), .CYC_I(CYC_I), .ACK_O(ACK_O),
      .ADC_DATA(ADC_DATA), .ADC_CMD(ADC_CMD));
   fe_model fe_model_i (.MCLK(MCLK), .RST_N(RST_N), .ADC_CMD(ADC_CMD), .ADC_DATA(ADC_DATA));

   always #4 MCLK = ~MCLK;

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task print_verdict();
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total = err_total + 1;
         print_verdict();
      end
   end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      num_checks = num_checks + 1;
      if (s !== e) begin
         err_total = err_total + 1;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I <= w;
      ADR_I <= a;
      DAT_I <= d;
      SEL_I <= 4'hF;
      // Only the bench timeout ends a wait for the answer
      do begin
         @(posedge MCLK);
      end while (ACK_O !== 1'b1);
      rd = DAT_O;
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
      WE_I <= 1'b0;
   endtask
   // Waits for n logged starts, then for power-down when asked
   task wait_log(input int n, input logic pd);
      int k;
      k = 0;
      while ((fe_model_i.log_q.size() < n || (pd && ADC_CMD.pwr_dn !== 1'b1)) && k < 9000) begin
         @(posedge MCLK);
         k = k + 1;
      end
      chk("wait", 32'(k < 9000), 32'h1);
   endtask
   task chk_log();
      chk("log_len", 32'(fe_model_i.log_q.size()), 32'(exq.size()));
      foreach (exq[i]) chk("slot", 32'(fe_model_i.log_q[i]), 32'(exq[i]));
   endtask
   function automatic logic [31:0] ex(input int s, input logic [15:0] b);
      logic [15:0] c;
      c = 16'((s / 2) + 1);
      if (s % 2 == 1) return {16'h0000, 13'(16'h0020 * c + b), 3'b000};
      return {16'h0000, 16'h0100 * c + b};
   endfunction

   // ------------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (10) @(posedge MCLK);
      RST_N <= 1'b1;
      wb(1'b0, OFS_CONFIG, 32'h0);
      chk("cfg_reset", rd, 32'h0000_7007);
      wb(1'b0, 8'h20, 32'h0);
      chk("unmapped", rd, 32'h0);
      wait_log(7, 1'b0);
      exq = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
      chk_log();
      wb(1'b0, OFS_MASK_EN, 32'h0);
      chk("flag_set", 32'(rd[FLAG_BIT]), 32'h1);
      wb(1'b0, OFS_MASK_EN, 32'h0);
      chk("flag_rd_clr", 32'(rd[FLAG_BIT]), 32'h0);
      for (int s = 0; s < 6; s++) begin
         wb(1'b0, 8'(OFS_RESULT0 + 4 * s), 32'h0);
         chk("result", rd, ex(s, 16'h0));
      end
      // Channel 2 off; the repeated code must run a second pass
      foreach (modes[i]) begin
         fe_model_i.log_q.delete();
         exq.delete();
         for (int s = 0; s < 6; s++) begin
            if (s / 2 != 1 && (s % 2 == 1 ? modes[i][MODE_BUS] : modes[i][MODE_SHUNT]))
               exq.push_back(3'(s));
         end
         wb(1'b1, OFS_CONFIG, {16'h0, 13'h0A00, modes[i]});
         wb(1'b0, OFS_MASK_EN, 32'h0);
         chk("flag_wr_clr", 32'(rd[FLAG_BIT]), 32'h0);
         wait_log(exq.size(), 1'b1);
         repeat (300) @(posedge MCLK);
         chk_log();
         wb(1'b0, OFS_MASK_EN, 32'h0);
         chk("pass_done", {29'h0, rd[2:0]}, 32'h5);
      end
      // Inactive codes power down and keep the flag
      // Log still holds the four starts of the last loop pass
      wb(1'b1, OFS_CONFIG, 32'h0000_5003);
      wait_log(8, 1'b1);
      wb(1'b1, OFS_CONFIG, 32'h0000_5000);
      wb(1'b1, OFS_CONFIG, 32'h0000_5004);
      wb(1'b0, OFS_MASK_EN, 32'h0);
      chk("pd_flag_kept", {29'h0, rd[2:0]}, 32'h5);
      wb(1'b0, OFS_CONFIG, 32'h0);
      chk("pd_cfg_rw", rd, 32'h0000_5004);
      wb(1'b0, 8'(OFS_RESULT0 + 20), 32'h0);
      chk("pd_result", rd, ex(5, 16'h0));
      // Averaging by four on channel 1
      fe_model_i.bias = 16'h0040;
      fe_model_i.log_q.delete();
      wb(1'b1, OFS_CONFIG, 32'h0000_1203);
      wait_log(2, 1'b1);
      for (int s = 0; s < 2; s++) begin
         wb(1'b0, 8'(OFS_RESULT0 + 4 * s), 32'h0);
         chk("average", rd, ex(s, 16'h0) + ((ex(s, 16'h40) - ex(s, 16'h0)) >> 2));
      end
      fe_model_i.log_q.delete();
      wb(1'b1, OFS_CONFIG, 32'h0000_7005);
      // Flag left set by the averaging pass; the active write must clear it
      wb(1'b0, OFS_MASK_EN, 32'h0);
      chk("flag_act_clr", 32'(rd[FLAG_BIT]), 32'h0);
      wait_log(7, 1'b0);
      exq = '{3'h0, 3'h2, 3'h4, 3'h0, 3'h2, 3'h4, 3'h0};
      chk_log();
      wb(1'b1, OFS_CONFIG, 32'h0000_4000);
      fe_model_i.log_q.delete();
      wb(1'b1, OFS_CONFIG, 32'h0000_4006);
      wait_log(3, 1'b0);
      exq = '{3'h5, 3'h5, 3'h5};
      chk_log();
      print_verdict();
   end
endmodule
